//--- include/cmd_limiter_pkg.sv
// Register map, reset values and limits of the speed and torque command limiter.
package cmd_limiter_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_SPD_UPPER = 8'h00;
  localparam logic [7:0] OFS_SPD_LOWER = 8'h04;
  localparam logic [7:0] OFS_TRQ_MAX = 8'h08;
  localparam logic [7:0] OFS_EXT_METHOD = 8'h0C;
  localparam logic [7:0] OFS_SPD_GAIN = 8'h10;
  localparam logic [7:0] OFS_SPD_OFFSET = 8'h14;
  localparam logic [7:0] OFS_TRQ_GAIN = 8'h18;
  localparam logic [7:0] OFS_TRQ_OFFSET = 8'h1C;
  localparam logic [7:0] OFS_CONTROL = 8'h20;
  localparam logic [7:0] OFS_OP_SPEED = 8'h24;
  localparam logic [7:0] OFS_OP_TORQUE = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  localparam logic [7:0] OFS_EFF_SPEED = 8'h30;
  localparam logic [7:0] OFS_EFF_TORQUE = 8'h34;
  localparam logic [7:0] OFS_SLOT_BASE = 8'h80;
  localparam int SLOT_FIRST = 13;
  localparam int SLOT_COUNT = 19;
  localparam logic [7:0] OFS_SLOT_END = OFS_SLOT_BASE + 8'(4 * SLOT_COUNT);

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_TRQ_EN = 0;
  localparam int CTRL_SPD_EXT = 1;
  localparam int CTRL_TRQ_EXT = 2;
  localparam int CTRL_CONFIG = 8;
  localparam int ST_SPD_CLAMP = 0;
  localparam int ST_TRQ_CLAMP = 1;
  localparam int ST_EXT_PWM = 2;
  localparam int ST_RUNNING = 3;

  // ****************************************
  // Limits and reset values
  // ****************************************
  localparam logic [11:0] SPD_MIN = 12'h050;
  localparam logic [11:0] SPD_MAX = 12'hC4E;
  localparam logic [11:0] SPD_SAT = 12'hFFF;
  localparam logic [7:0] TRQ_PEAK = 8'hC8;
  localparam logic signed [11:0] SPD_OFF_LIM = 12'sh5DC;
  localparam logic signed [7:0] TRQ_OFF_LIM = 8'sh64;
  localparam logic [11:0] RST_SPD_UPPER = SPD_MAX;
  localparam logic [11:0] RST_SPD_LOWER = SPD_MIN;
  localparam logic [7:0] RST_TRQ_MAX = TRQ_PEAK;
  localparam logic [11:0] RST_SPD_GAIN = 12'h280;
  localparam logic [7:0] RST_TRQ_GAIN = 8'h2B;
  localparam logic RST_EXT_METHOD = 1'b0;
  localparam logic RST_TRQ_EN = 1'b1;
  localparam int ANALOG_W = 13;
  localparam int FRAC = 10;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [0:SLOT_COUNT-1][15:0] SLOT_DEFAULT = {
    16'h009D, 16'h007F, 16'h007E, 16'h00A0, 16'h00A1,
    16'h00B8, 16'h00B9, 16'h00BA, 16'h00BB, 16'h00BC, 16'h00BD, 16'h00BE, 16'h00BF,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

endpackage

//--- logic/speed_torque_command_limiter.sv
// Speed and torque command conditioning with an AXI4-Lite register file.
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.

// Summary of operation
// RL1 - Speed upper limit 80 to 3150, default 3150.
// RL2 - Speed lower limit 80 to 3150, default 80.
// RL3 - Speed above upper limit runs at upper.
// RL4 - Speed below lower limit raised to lower.
// RL5 - Commands 0 to 79 skip lower clamping.
// RL6 - Speed clamping raises speed info flag.
// RL7 - Torque maximum 0 to 200, default 200.
// RL8 - Torque above maximum uses the maximum.
// RL9 - Torque clamping raises torque info flag.
// RL10 - Limiting disabled: cap 200, no flag.
// RL11 - Method 0 analog, 1 PWM, after configuration.
// RL12 - PWM source uses measured input duty cycle.
// RL13 - Speed gain 0 to 3150 per volt, default 640.
// RL14 - Speed offset -1500 to +1500, default 0.
// RL15 - Torque gain 0 to 200 per volt, default 43.
// RL16 - Torque offset -100 to +100, default 0.
// RL17 - Negative offset: stopped until command reaches 80.
// RL18 - Updates: A immediate, B stopped, C configure.
// RL19 - Slots 13 to 25 hold documented default addresses.
// RL20 - Slots 26 to 31 default 0, 16-bit values.
// RL21 - Analog command is voltage times gain plus offset.
module speed_torque_command_limiter
  import cmd_limiter_pkg::*;
#(
  parameter int PWM_WIN_LOG2 = 16
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic running_i,
  input wire logic [ANALOG_W-1:0] analog_v_i,
  input wire logic pwm_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [11:0] speed_cmd_o,
  output logic [7:0] torque_limit_o,
  output logic speed_clamp_info_flag_o,
  output logic torque_clamp_info_flag_o
);

  // ****************************************
  // Parameter storage
  // ****************************************
  logic [11:0] upper_w;
  logic [11:0] lower_w;
  logic [7:0] tmax_w;
  logic ext_pwm_w;
  logic [11:0] upper_a;
  logic [11:0] lower_a;
  logic [7:0] tmax_a;
  logic ext_pwm_a;
  logic [11:0] spd_gain;
  logic signed [11:0] spd_off;
  logic [7:0] trq_gain;
  logic signed [7:0] trq_off;
  logic trq_en;
  logic spd_ext;
  logic trq_ext;
  logic cfg_pulse;
  logic [11:0] op_speed;
  logic [7:0] op_torque;
  logic [15:0] slot [0:SLOT_COUNT-1];

  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic [31:0] wr_val;

  logic pwm_s1;
  logic pwm_s2;
  logic [PWM_WIN_LOG2-1:0] win_cnt;
  logic [PWM_WIN_LOG2:0] high_cnt;
  logic [PWM_WIN_LOG2:0] high_total;
  logic [FRAC:0] duty;

  logic [11:0] next_speed;
  logic [7:0] next_torque;
  logic next_spd_flag;
  logic next_trq_flag;

  function automatic logic [11:0] sat_u(input logic [11:0] v, input logic [11:0] lo,
                                        input logic [11:0] hi);
    logic [11:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  function automatic logic signed [11:0] sat_s(input logic signed [11:0] v,
                                               input logic signed [11:0] lim);
    logic signed [11:0] r;
    r = v;
    if (v > lim) begin
      r = lim;
    end else if (v < -lim) begin
      r = -lim;
    end
    return r;
  endfunction

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'b00) &&
           ((a <= OFS_EFF_TORQUE) || ((a >= OFS_SLOT_BASE) && (a < OFS_SLOT_END)));
  endfunction

  function automatic logic [4:0] slot_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - OFS_SLOT_BASE;
    return d[6:2];
  endfunction

  function automatic logic [31:0] reg_read(input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    v = '0;
    if (a == OFS_SPD_UPPER) begin
      v[11:0] = upper_w;
    end else if (a == OFS_SPD_LOWER) begin
      v[11:0] = lower_w;
    end else if (a == OFS_TRQ_MAX) begin
      v[7:0] = tmax_w;
    end else if (a == OFS_EXT_METHOD) begin
      v[0] = ext_pwm_w;
    end else if (a == OFS_SPD_GAIN) begin
      v[11:0] = spd_gain;
    end else if (a == OFS_SPD_OFFSET) begin
      v[11:0] = spd_off;
    end else if (a == OFS_TRQ_GAIN) begin
      v[7:0] = trq_gain;
    end else if (a == OFS_TRQ_OFFSET) begin
      v[7:0] = trq_off;
    end else if (a == OFS_CONTROL) begin
      v[CTRL_TRQ_EN] = trq_en;
      v[CTRL_SPD_EXT] = spd_ext;
      v[CTRL_TRQ_EXT] = trq_ext;
    end else if (a == OFS_OP_SPEED) begin
      v[11:0] = op_speed;
    end else if (a == OFS_OP_TORQUE) begin
      v[7:0] = op_torque;
    end else if (a == OFS_STATUS) begin
      v[ST_SPD_CLAMP] = speed_clamp_info_flag_o;
      v[ST_TRQ_CLAMP] = torque_clamp_info_flag_o;
      v[ST_EXT_PWM] = ext_pwm_a;
      v[ST_RUNNING] = running_i;
    end else if (a == OFS_EFF_SPEED) begin
      v[11:0] = speed_cmd_o;
    end else if (a == OFS_EFF_TORQUE) begin
      v[7:0] = torque_limit_o;
    end else if (reg_hit(a)) begin
      v[15:0] = slot[slot_idx(a)];
    end
    return v;
  endfunction

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  // A ready that is low means the channel's item is held until the response is taken.
  assign wr_go = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;

  always_comb begin
    wr_val = reg_read(aw_addr);
    for (int b = 0; b < 4; b++) begin
      if (w_strb[b]) begin
        wr_val[8*b +: 8] = w_data[8*b +: 8];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_addr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= reg_hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= reg_read(s_axi_araddr_i);
        s_axi_rresp_o <= reg_hit(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // ****************************************
  // Parameter writes
  // ****************************************
  // Writes outside a field's range saturate, so the active limits can never leave it.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      upper_w <= RST_SPD_UPPER; // RL1
      lower_w <= RST_SPD_LOWER; // RL2
      tmax_w <= RST_TRQ_MAX; // RL7
      ext_pwm_w <= RST_EXT_METHOD; // RL11
      spd_gain <= RST_SPD_GAIN; // RL13
      spd_off <= '0; // RL14
      trq_gain <= RST_TRQ_GAIN; // RL15
      trq_off <= '0; // RL16
      trq_en <= RST_TRQ_EN;
      spd_ext <= 1'b0;
      trq_ext <= 1'b0;
      cfg_pulse <= 1'b0;
      op_speed <= '0;
      op_torque <= '0;
    end else if (ce_i) begin
      cfg_pulse <= 1'b0;
      if (wr_go && reg_hit(aw_addr)) begin
        if (aw_addr == OFS_SPD_UPPER) begin
          upper_w <= sat_u(wr_val[11:0], SPD_MIN, SPD_MAX); // RL1
        end else if (aw_addr == OFS_SPD_LOWER) begin
          lower_w <= sat_u(wr_val[11:0], SPD_MIN, SPD_MAX); // RL2
        end else if (aw_addr == OFS_TRQ_MAX) begin
          tmax_w <= 8'(sat_u({4'h0, wr_val[7:0]}, 12'h000, {4'h0, TRQ_PEAK})); // RL7
        end else if (aw_addr == OFS_EXT_METHOD) begin
          ext_pwm_w <= wr_val[0]; // RL11
        end else if (aw_addr == OFS_SPD_GAIN) begin
          spd_gain <= sat_u(wr_val[11:0], 12'h000, SPD_MAX); // RL13
        end else if (aw_addr == OFS_SPD_OFFSET) begin
          spd_off <= sat_s(wr_val[11:0], SPD_OFF_LIM); // RL14
        end else if (aw_addr == OFS_TRQ_GAIN) begin
          trq_gain <= 8'(sat_u({4'h0, wr_val[7:0]}, 12'h000, {4'h0, TRQ_PEAK})); // RL15
        end else if (aw_addr == OFS_TRQ_OFFSET) begin
          trq_off <= 8'(sat_s({{4{wr_val[7]}}, wr_val[7:0]}, 12'(TRQ_OFF_LIM))); // RL16
        end else if (aw_addr == OFS_CONTROL) begin
          trq_en <= wr_val[CTRL_TRQ_EN];
          spd_ext <= wr_val[CTRL_SPD_EXT];
          trq_ext <= wr_val[CTRL_TRQ_EXT];
          cfg_pulse <= wr_val[CTRL_CONFIG];
        end else if (aw_addr == OFS_OP_SPEED) begin
          op_speed <= wr_val[11:0];
        end else if (aw_addr == OFS_OP_TORQUE) begin
          op_torque <= wr_val[7:0];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      for (int i = 0; i < SLOT_COUNT; i++) begin
        slot[i] <= SLOT_DEFAULT[i]; // RL19 RL20
      end
    end else if (ce_i) begin
      if (wr_go && (aw_addr >= OFS_SLOT_BASE) && reg_hit(aw_addr)) begin
        slot[slot_idx(aw_addr)] <= wr_val[15:0]; // RL20
      end
    end
  end

  // ****************************************
  // Update classes
  // ****************************************
  // Gains, offsets and control bits act straight from storage; limits wait for a stop.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      upper_a <= RST_SPD_UPPER;
      lower_a <= RST_SPD_LOWER;
      tmax_a <= RST_TRQ_MAX;
      ext_pwm_a <= RST_EXT_METHOD;
    end else if (ce_i) begin
      if (!running_i) begin
        upper_a <= upper_w; // RL18
        lower_a <= lower_w; // RL18
        tmax_a <= tmax_w; // RL18
      end
      if (cfg_pulse) begin
        ext_pwm_a <= ext_pwm_w; // RL18 RL11
      end
    end
  end

  // ****************************************
  // PWM duty measurement
  // ****************************************
  // Duty is the share of high samples over a fixed window, which avoids a divider
  // at the cost of one window of latency.
  assign high_total = high_cnt + {{PWM_WIN_LOG2{1'b0}}, pwm_s2};

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pwm_s1 <= 1'b0;
      pwm_s2 <= 1'b0;
      win_cnt <= '0;
      high_cnt <= '0;
      duty <= '0;
    end else if (ce_i) begin
      pwm_s1 <= pwm_i;
      pwm_s2 <= pwm_s1;
      win_cnt <= win_cnt + 1'b1;
      if (&win_cnt) begin
        duty <= high_total[PWM_WIN_LOG2 -: FRAC+1]; // RL12
        high_cnt <= '0;
      end else begin
        high_cnt <= high_total;
      end
    end
  end

  // ****************************************
  // Command sources and clamping
  // ****************************************
  always_comb begin
    logic [24:0] a_sprod;
    logic [20:0] a_tprod;
    logic signed [17:0] a_ssum;
    logic signed [12:0] a_tsum;
    logic [11:0] a_spd;
    logic [7:0] a_trq;
    logic [22:0] p_sprod;
    logic [18:0] p_tprod;
    logic [11:0] spd_cmd;
    logic [7:0] trq_cmd;
    a_spd = '0;
    a_trq = '0;
    a_sprod = analog_v_i * spd_gain;
    a_tprod = analog_v_i * trq_gain;
    a_ssum = $signed({3'b000, a_sprod[24:FRAC]}) + 18'(spd_off); // RL21
    a_tsum = $signed({2'b00, a_tprod[20:FRAC]}) + 13'(trq_off); // RL21
    if (a_ssum < 0) begin
      a_spd = '0;
    end else if ((spd_off < 0) && (a_ssum[16:0] < 17'(SPD_MIN))) begin
      a_spd = '0; // RL17
    end else if (a_ssum[16:0] > 17'(SPD_SAT)) begin
      a_spd = SPD_SAT;
    end else begin
      a_spd = a_ssum[11:0];
    end
    if (a_tsum < 0) begin
      a_trq = '0;
    end else if (a_tsum[11:0] > 12'(TRQ_PEAK)) begin
      a_trq = TRQ_PEAK;
    end else begin
      a_trq = a_tsum[7:0];
    end
    p_sprod = duty * SPD_MAX;
    p_tprod = duty * TRQ_PEAK;
    spd_cmd = op_speed;
    if (spd_ext) begin
      spd_cmd = ext_pwm_a ? p_sprod[21:FRAC] : a_spd; // RL11 RL12
    end
    trq_cmd = op_torque;
    if (trq_ext) begin
      trq_cmd = ext_pwm_a ? p_tprod[17:FRAC] : a_trq; // RL11 RL12
    end
    next_speed = spd_cmd;
    next_spd_flag = 1'b0;
    if (spd_cmd > upper_a) begin
      next_speed = upper_a; // RL3
      next_spd_flag = 1'b1; // RL6
    end else if ((spd_cmd >= SPD_MIN) && (spd_cmd < lower_a)) begin
      next_speed = lower_a; // RL4 RL5
      next_spd_flag = 1'b1; // RL6
    end
    next_torque = trq_cmd;
    next_trq_flag = 1'b0;
    if (!trq_en) begin
      next_torque = (trq_cmd > TRQ_PEAK) ? TRQ_PEAK : trq_cmd; // RL10
    end else if (trq_cmd > tmax_a) begin
      next_torque = tmax_a; // RL8
      next_trq_flag = 1'b1; // RL9
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      speed_cmd_o <= '0;
      torque_limit_o <= '0;
      speed_clamp_info_flag_o <= 1'b0;
      torque_clamp_info_flag_o <= 1'b0;
    end else if (ce_i) begin
      speed_cmd_o <= next_speed;
      torque_limit_o <= next_torque;
      speed_clamp_info_flag_o <= next_spd_flag; // RL6
      torque_clamp_info_flag_o <= next_trq_flag; // RL9 RL10
    end
  end

endmodule

//--- verification/limiter_properties.sv
// Port properties of the speed and torque command limiter.
module limiter_properties
  import cmd_limiter_pkg::*;
#(
  parameter int PWM_WIN_LOG2 = 16
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [11:0] speed_cmd_o,
  input wire logic [7:0] torque_limit_o,
  input wire logic speed_clamp_info_flag_o,
  input wire logic torque_clamp_info_flag_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  reset_clear_a: assert property ($fell(reset_i) |-> !speed_clamp_info_flag_o
    && !torque_clamp_info_flag_o && speed_cmd_o == 12'h000 && torque_limit_o == 8'h00)
    else $error("outputs not cleared by reset");
  speed_ceiling_a: assert property (speed_cmd_o <= SPD_MAX)
    else $error("speed command above ceiling");
  torque_ceiling_a: assert property (torque_limit_o <= TRQ_PEAK)
    else $error("torque limit above peak");
  clamp_floor_a: assert property (speed_clamp_info_flag_o |-> speed_cmd_o >= SPD_MIN)
    else $error("speed flag with a low speed");
  write_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o) else $error("write response late");
  write_busy_a: assert property (s_axi_awvalid_i && s_axi_awready_o
    |=> !s_axi_awready_o [*2]) else $error("address taken during write");
  write_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i
    |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
  read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read response late");
  read_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i
    |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");

  cover property (speed_clamp_info_flag_o);
  cover property (torque_clamp_info_flag_o);
  cover property (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR);
endmodule

//--- verification/ext_source.sv
// Model of the external speed sources: a PWM generator and an analog voltage.
module ext_source (
  input wire logic clk_sys_i,
  input wire logic [6:0] duty_i,
  input wire logic [12:0] volts_i,
  output logic pwm_o,
  output logic [12:0] analog_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] phase = 6'h00;

  // A 64-cycle period divides the measuring window, so the duty reads exact at any phase.
  always @(posedge clk_sys_i) begin
    phase <= phase + 6'h01;
    pwm_o <= ({1'b0, phase} < duty_i);
  end
  assign analog_o = volts_i;
endmodule

//--- verification/tb.sv
// Self-checking bench of the speed and torque command limiter.
bind speed_torque_command_limiter limiter_properties #(.PWM_WIN_LOG2(PWM_WIN_LOG2)) i_props (.*);

module tb
  import cmd_limiter_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1, running_i = 1'b0, pwm_i;
  logic [ANALOG_W-1:0] analog_v_i;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0000_0000, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hF;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [11:0] speed_cmd_o;
  logic [7:0] torque_limit_o;
  logic speed_clamp_info_flag_o, torque_clamp_info_flag_o;
  logic [31:0] seed = 32'h3128_bba6;
  int failures = 0, cmp_count = 0;
  int up = 3150, lo = 80, tmax = 200, ten = 1, spd = 0, trq = 0, sext = 0, text = 0, meth = 0;
  int duty = 0, volts = 0, sg = 640, so = 0, tg = 43, toff = 0;
  logic [7:0] da[10] = '{OFS_SPD_UPPER, OFS_SPD_LOWER, OFS_TRQ_MAX, OFS_EXT_METHOD,
    OFS_SPD_GAIN, OFS_SPD_OFFSET, OFS_TRQ_GAIN, OFS_TRQ_OFFSET, OFS_CONTROL, OFS_STATUS};
  int dv[10] = '{3150, 80, 200, 0, 640, 0, 43, 0, 1, 0};
  int sx[19] = '{157, 127, 126, 160, 161, 184, 185, 186, 187, 188, 189, 190, 191,
    0, 0, 0, 0, 0, 0};

  always #20 clk_sys_i = ~clk_sys_i;

  ext_source i_src (.clk_sys_i(clk_sys_i), .duty_i(duty[6:0]), .volts_i(volts[12:0]),
    .pwm_o(pwm_i), .analog_o(analog_v_i));
  // A short window keeps the PWM scenario brief.
  speed_torque_command_limiter #(.PWM_WIN_LOG2(10)) i_dut (.*);

  function automatic int rnd(input int n);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return int'(seed % n);
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
    chk("bresp", er, s_axi_bresp_o);
  endtask

  task automatic rdr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b0;
    chk("rdata", ed, s_axi_rdata_o);
    chk("rresp", er, s_axi_rresp_o);
  endtask

  // Model of the conditioned outputs, compared once the updates have settled.
  task automatic chk_out();
    int s;
    int t;
    int sf;
    int tf;
    repeat (4) @(posedge clk_sys_i);
    if (sext == 0) s = spd;
    else if (meth == 1) s = (duty * 16 * 3150) >> 10;
    else s = ((volts * sg) >> 10) + so;
    if (s < 0 || (sext == 1 && meth == 0 && so < 0 && s < 80)) s = 0;
    if (s > 4095) s = 4095;
    sf = 0;
    if (s > up) begin
      s = up;
      sf = 1;
    end else if (s >= 80 && s < lo) begin
      s = lo;
      sf = 1;
    end
    if (text == 0) t = trq;
    else if (meth == 1) t = (duty * 16 * 200) >> 10;
    else t = ((volts * tg) >> 10) + toff;
    if (t < 0) t = 0;
    if (t > 200 && (text == 1 || ten == 0)) t = 200;
    tf = 0;
    if (ten == 1 && t > tmax) begin
      t = tmax;
      tf = 1;
    end
    chk("speed_cmd", s, speed_cmd_o);
    chk("speed_flag", sf, speed_clamp_info_flag_o);
    chk("torque_limit", t, torque_limit_o);
    chk("torque_flag", tf, torque_clamp_info_flag_o);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #3_000_000;
    failures++;
    test_done();
  end

  initial begin
    int cs[8];
    int v;
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    chk_out();
    for (int i = 0; i < 10; i++) rdr(da[i], dv[i], RESP_OKAY);
    for (int i = 0; i < SLOT_COUNT; i++) rdr(8'(OFS_SLOT_BASE + 4 * i), sx[i], RESP_OKAY);
    wr(8'hC8, 32'h0000_FFFF, RESP_OKAY);
    rdr(8'hC8, 32'h0000_FFFF, RESP_OKAY);
    wr(8'h40, 32'h0000_0001, RESP_SLVERR);
    rdr(8'h40, 32'h0000_0000, RESP_SLVERR);
    rdr(8'h02, 32'h0000_0000, RESP_SLVERR);
    rdr(OFS_SLOT_END, 32'h0000_0000, RESP_SLVERR);
    $display("test registers done");
    for (int i = 0; i < 40; i++) begin
      up = 80 + rnd(3071);
      lo = 80 + rnd(up - 79);
      tmax = rnd(201);
      cs = '{0, 79, 80, lo - 1, lo, up, up + 1, 4095};
      spd = (i < 8) ? cs[i] : rnd(4096);
      trq = (i < 8) ? tmax + i : rnd(256);
      wr(OFS_SPD_UPPER, up, RESP_OKAY);
      wr(OFS_SPD_LOWER, lo, RESP_OKAY);
      wr(OFS_TRQ_MAX, tmax, RESP_OKAY);
      wr(OFS_OP_SPEED, spd, RESP_OKAY);
      wr(OFS_OP_TORQUE, trq, RESP_OKAY);
      chk_out();
    end
    $display("test digital limits done");
    running_i <= 1'b1;
    spd = 3000;
    wr(OFS_SPD_UPPER, 100, RESP_OKAY);
    wr(OFS_SPD_LOWER, 80, RESP_OKAY);
    wr(OFS_OP_SPEED, spd, RESP_OKAY);
    chk_out();
    running_i <= 1'b0;
    up = 100;
    lo = 80;
    chk_out();
    $display("test update class done");
    ten = 0;
    trq = 250;
    tmax = 50;
    wr(OFS_CONTROL, 32'h0000_0000, RESP_OKAY);
    wr(OFS_TRQ_MAX, tmax, RESP_OKAY);
    wr(OFS_OP_TORQUE, trq, RESP_OKAY);
    chk_out();
    $display("test torque disable done");
    ten = 1;
    sext = 1;
    text = 1;
    up = 3150;
    wr(OFS_SPD_UPPER, up, RESP_OKAY);
    wr(OFS_CONTROL, 32'h0000_0007, RESP_OKAY);
    for (int i = 0; i < 12; i++) begin
      v = rnd(8192);
      sg = rnd(3151);
      so = rnd(3001) - 1500;
      tg = rnd(201);
      toff = rnd(201) - 100;
      if (i < 2) begin
        v = (i == 0) ? 240 : 100;
        sg = 640;
        so = (i == 0) ? -100 : 0;
      end
      volts <= v;
      wr(OFS_SPD_GAIN, sg, RESP_OKAY);
      wr(OFS_SPD_OFFSET, so, RESP_OKAY);
      wr(OFS_TRQ_GAIN, tg, RESP_OKAY);
      wr(OFS_TRQ_OFFSET, toff, RESP_OKAY);
      chk_out();
    end
    $display("test analog done");
    duty <= 20;
    wr(OFS_EXT_METHOD, 32'h0000_0001, RESP_OKAY);
    chk_out();
    wr(OFS_CONTROL, 32'h0000_0107, RESP_OKAY);
    meth = 1;
    for (int i = 0; i < 3; i++) begin
      duty <= (i == 0) ? 20 : (i == 1) ? 0 : 63;
      repeat (2600) @(posedge clk_sys_i);
      chk_out();
    end
    $display("test pwm done");
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    tmax = 200;
    spd = 0;
    trq = 0;
    sext = 0;
    text = 0;
    meth = 0;
    chk_out();
    rdr(OFS_EXT_METHOD, 32'h0000_0000, RESP_OKAY);
    rdr(OFS_TRQ_MAX, 32'h0000_00C8, RESP_OKAY);
    $display("test second reset done");
    test_done();
  end
endmodule
